// ---- tcc_pkg.sv ----
`default_nettype none
package tcc_pkg;

	// Register word offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_PRESC  = 8'h04;
	localparam logic [7:0] OFF_FORCE  = 8'h08;
	localparam logic [7:0] OFF_FLAG   = 8'h0C;
	localparam logic [7:0] OFF_IRQEN  = 8'h10;
	localparam logic [7:0] OFF_CNT_L  = 8'h14;
	localparam logic [7:0] OFF_CNT_H  = 8'h18;
	localparam logic [7:0] OFF_CAP_L  = 8'h1C;
	localparam logic [7:0] OFF_CAP_H  = 8'h20;
	localparam logic [7:0] OFF_CMPA_L = 8'h24;
	localparam logic [7:0] OFF_CMPA_H = 8'h28;
	localparam logic [7:0] OFF_CMPB_L = 8'h2C;
	localparam logic [7:0] OFF_CMPB_H = 8'h30;
	localparam logic [7:0] OFF_STATUS = 8'h34;

	// Flag and enable bit positions
	localparam int FLAG_CMP_A = 0;
	localparam int FLAG_CMP_B = 1;
	localparam int FLAG_CAPT  = 2;

	// Reset values
	localparam logic [9:0]  CTRL_RESET  = 10'h000;
	localparam logic [15:0] PRESC_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET   = 16'h0000;

	// Waveform modes with a special meaning here
	localparam logic [3:0] WGM_NORMAL  = 4'h0;
	localparam logic [3:0] WGM_PC8     = 4'h1;
	localparam logic [3:0] WGM_PC9     = 4'h2;
	localparam logic [3:0] WGM_PC10    = 4'h3;
	localparam logic [3:0] WGM_CTC_A   = 4'h4;
	localparam logic [3:0] WGM_FAST8   = 4'h5;
	localparam logic [3:0] WGM_FAST9   = 4'h6;
	localparam logic [3:0] WGM_FAST10  = 4'h7;
	localparam logic [3:0] WGM_PFC_I   = 4'h8;
	localparam logic [3:0] WGM_PFC_A   = 4'h9;
	localparam logic [3:0] WGM_PC_I    = 4'hA;
	localparam logic [3:0] WGM_PC_A    = 4'hB;
	localparam logic [3:0] WGM_CTC_I   = 4'hC;
	localparam logic [3:0] WGM_RSVD    = 4'hD;
	localparam logic [3:0] WGM_FAST_I  = 4'hE;
	localparam logic [3:0] WGM_FAST_A  = 4'hF;

	localparam logic [15:0] TOP_8BIT  = 16'h00FF;
	localparam logic [15:0] TOP_9BIT  = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX   = 16'hFFFF;

	// Control register layout, bit 9 down to bit 0
	typedef struct packed {
		logic       run;
		logic       retrig_en;
		logic [3:0] waveform_mode;
		logic [1:0] com_b;
		logic [1:0] com_a;
	} tcc_ctrl_type;

	// Bus data-phase sequencing
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} tcc_bus_state_type;

endpackage
`default_nettype wire

// ---- tcc_timer16.sv ----
// What this block does
// - A capture copies the counter and sets the capture flag in the same cycle.
// - Each later capture overwrites the capture register, read or not.
// - With retrigger enabled, a capture is ORed into the top-reached signal.
// - Each channel compares counter and compare value; equality sets its flag next tick.
// - A set compare flag requests an interrupt when enabled; servicing clears it.
// - Writing one to a compare flag clears it; writing zero leaves it.
// - Compare channel A can supply the counter top value.
// - Compare values are double buffered in PWM modes, updated at top; otherwise direct.
// - CPU compare writes reach the buffer when buffering, else the active register.
// - Compare high byte reads return the register directly, not the shared byte.
// - High byte write loads the shared byte; low byte write copies it up, for capture only in ICR-top modes.
// - Force strobe in non-PWM modes updates the output latch only, like a match.
// - A CPU counter write blocks every compare match at the next timer tick.
// - Counter written equal to a variable top in PWM skips that top, runs to 0xFFFF.
// - Output latches keep their value across mode changes; reset clears them.
// - Output mode bits are unbuffered and act at once on the pin select, and on the latch at the next match or PWM top.
// - A nonzero output mode puts the latch on the pin; direction still controls drive.
// - Output mode zero leaves the latch unchanged on a match.
// - Output mode bits do not affect input capture.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16 (
	input  wire logic        hclk,          // System clock
	input  wire logic        hresetn,       // Async reset, active low
	input  wire logic        hsel,          // Slave select
	input  wire logic [31:0] haddr,         // Byte address
	input  wire logic [1:0]  htrans,        // Transfer type
	input  wire logic        hwrite,        // Write when high
	input  wire logic [2:0]  hsize,         // Transfer size
	input  wire logic [31:0] hwdata,        // Write data
	input  wire logic        hready,        // Bus ready
	output logic             hreadyout,     // Slave ready
	output logic [31:0]      hrdata,        // Read data
	output logic             hresp,         // Always OKAY
	input  wire logic        capture_event, // Qualified capture pulse
	input  wire logic [1:0]  irq_ack,       // Compare interrupt serviced, per channel
	input  wire logic        capt_irq_ack,  // Capture interrupt serviced
	input  wire logic [1:0]  port_value,    // General port value per pin
	input  wire logic [1:0]  pin_direction, // Pin direction bits, 1 = output
	output logic [1:0]       pin_out,       // Pin output level
	output logic [1:0]       pin_oe,        // Pin output enable
	output logic [1:0]       irq_req,       // Compare interrupt requests
	output logic             capt_irq_req,  // Capture interrupt request
	output logic             top_reached    // One-cycle top pulse to counter logic
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = !(m == tcc_pkg::WGM_NORMAL || m == tcc_pkg::WGM_CTC_A ||
			m == tcc_pkg::WGM_CTC_I || m == tcc_pkg::WGM_RSVD);
	endfunction

	function automatic logic icr_is_top(input logic [3:0] m);
		icr_is_top = (m == tcc_pkg::WGM_PFC_I || m == tcc_pkg::WGM_PC_I ||
			m == tcc_pkg::WGM_CTC_I || m == tcc_pkg::WGM_FAST_I);
	endfunction

	function automatic logic on_match(input logic [1:0] com, input logic cur);
		case (com)
			2'h1:    on_match = ~cur;
			2'h2:    on_match = 1'b0;
			2'h3:    on_match = 1'b1;
			default: on_match = cur;
		endcase
	endfunction

	function automatic logic at_count_lower_limit(input logic [1:0] com, input logic cur);
		case (com)
			2'h2:    at_count_lower_limit = 1'b1;
			2'h3:    at_count_lower_limit = 1'b0;
			default: at_count_lower_limit = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	tcc_pkg::tcc_ctrl_type        ctrl_q;
	tcc_pkg::tcc_bus_state_type   bus_q;
	logic [7:0]                   addr_q;
	logic [15:0]                  presc_q;
	logic [15:0]                  div_q;
	logic [15:0]                  count_q;
	logic [15:0]                  capture_reg_q;
	logic [15:0]                  cmp_act_q [2];
	logic [15:0]                  cmp_buf_q [2];
	logic [7:0]                   tmp_q;
	logic [1:0]                   compare_flag_q;
	logic                         capture_flag_q;
	logic [1:0]                   compare_irq_enable_q;
	logic                         capt_irq_enable_q;
	logic [1:0]                   latch_q;
	logic                         block_q;
	logic                         rtg_pend_q;
	logic [31:0]                  hrdata_q;
	logic                         top_q;

	logic                         pwm;
	logic                         tick;
	logic [15:0]                  top_val;
	logic                         top_hit;
	logic                         capt_fire;
	logic                         wr;
	logic [7:0]                   wlo;
	logic [1:0]                   match;
	logic [1:0]                   force_cmp;

	assign pwm       = is_pwm(ctrl_q.waveform_mode);
	assign tick      = ctrl_q.run && (div_q == presc_q);
	assign wr        = (bus_q == tcc_pkg::BUS_WRITE);
	assign wlo       = hwdata[7:0];
	assign capt_fire = capture_event && !icr_is_top(ctrl_q.waveform_mode);
	assign force_cmp = (wr && addr_q == tcc_pkg::OFF_FORCE && !pwm) ? hwdata[1:0] : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Top value and top detection

	always_comb begin
		case (ctrl_q.waveform_mode)
			tcc_pkg::WGM_PC8, tcc_pkg::WGM_FAST8:   top_val = tcc_pkg::TOP_8BIT;
			tcc_pkg::WGM_PC9, tcc_pkg::WGM_FAST9:   top_val = tcc_pkg::TOP_9BIT;
			tcc_pkg::WGM_PC10, tcc_pkg::WGM_FAST10: top_val = tcc_pkg::TOP_10BIT;
			tcc_pkg::WGM_CTC_A, tcc_pkg::WGM_PFC_A,
			tcc_pkg::WGM_PC_A, tcc_pkg::WGM_FAST_A: top_val = cmp_act_q[0];
			tcc_pkg::WGM_PFC_I, tcc_pkg::WGM_PC_I,
			tcc_pkg::WGM_CTC_I, tcc_pkg::WGM_FAST_I: top_val = capture_reg_q;
			default:                                top_val = tcc_pkg::TOP_MAX;
		endcase
	end

	// A blocked top match lets the counter run on past top to the wrap
	assign top_hit = ((count_q == top_val) && !block_q) || rtg_pend_q;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			match[i] = tick && !block_q && (count_q == cmp_act_q[i]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave sequencing

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q  <= tcc_pkg::BUS_IDLE;
			addr_q <= 8'h00;
		end else begin
			case (bus_q)
				tcc_pkg::BUS_READ_WAIT: bus_q <= tcc_pkg::BUS_READ_DONE;
				default: begin
					if (hsel && hready && htrans[1]) begin
						addr_q <= {haddr[7:2], 2'b00};
						if (hwrite && hsize == 3'b010) begin
							bus_q <= tcc_pkg::BUS_WRITE;
						end else if (!hwrite) begin
							bus_q <= tcc_pkg::BUS_READ_WAIT;
						end else begin
							bus_q <= tcc_pkg::BUS_IDLE;
						end
					end else begin
						bus_q <= tcc_pkg::BUS_IDLE;
					end
				end
			endcase
		end
	end

	assign hreadyout = (bus_q != tcc_pkg::BUS_READ_WAIT);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// Read data, captured one cycle into the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (bus_q == tcc_pkg::BUS_READ_WAIT) begin
			case (addr_q)
				tcc_pkg::OFF_CTRL:   hrdata_q <= {22'h0, ctrl_q};
				tcc_pkg::OFF_PRESC:  hrdata_q <= {16'h0, presc_q};
				tcc_pkg::OFF_FLAG:   hrdata_q <= {29'h0, capture_flag_q, compare_flag_q};
				tcc_pkg::OFF_IRQEN:  hrdata_q <= {29'h0, capt_irq_enable_q, compare_irq_enable_q};
				tcc_pkg::OFF_CNT_L:  hrdata_q <= {24'h0, count_q[7:0]};
				tcc_pkg::OFF_CNT_H:  hrdata_q <= {24'h0, tmp_q};
				tcc_pkg::OFF_CAP_L:  hrdata_q <= {24'h0, capture_reg_q[7:0]};
				tcc_pkg::OFF_CAP_H:  hrdata_q <= {24'h0, tmp_q};
				tcc_pkg::OFF_CMPA_L: hrdata_q <= {24'h0, pwm ? cmp_buf_q[0][7:0] : cmp_act_q[0][7:0]};
				tcc_pkg::OFF_CMPA_H: hrdata_q <= {24'h0, pwm ? cmp_buf_q[0][15:8] : cmp_act_q[0][15:8]};
				tcc_pkg::OFF_CMPB_L: hrdata_q <= {24'h0, pwm ? cmp_buf_q[1][7:0] : cmp_act_q[1][7:0]};
				tcc_pkg::OFF_CMPB_H: hrdata_q <= {24'h0, pwm ? cmp_buf_q[1][15:8] : cmp_act_q[1][15:8]};
				tcc_pkg::OFF_STATUS: hrdata_q <= {29'h0, block_q, latch_q};
				default:             hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, prescaler and enables

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q               <= tcc_pkg::CTRL_RESET;
			presc_q              <= tcc_pkg::PRESC_RESET;
			compare_irq_enable_q <= 2'h0;
			capt_irq_enable_q    <= 1'b0;
		end else if (wr) begin
			if (addr_q == tcc_pkg::OFF_CTRL) begin
				ctrl_q <= hwdata[9:0];
			end
			if (addr_q == tcc_pkg::OFF_PRESC) begin
				presc_q <= hwdata[15:0];
			end
			if (addr_q == tcc_pkg::OFF_IRQEN) begin
				compare_irq_enable_q <= hwdata[1:0];
				capt_irq_enable_q    <= hwdata[2];
			end
		end
	end

	// Timer clock enable divider
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 16'h0000;
		end else if (!ctrl_q.run || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared high-byte temporary register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmp_q <= 8'h00;
		end else if (wr && (addr_q == tcc_pkg::OFF_CNT_H || addr_q == tcc_pkg::OFF_CAP_H ||
			addr_q == tcc_pkg::OFF_CMPA_H || addr_q == tcc_pkg::OFF_CMPB_H)) begin
			tmp_q <= wlo;
		end else if (bus_q == tcc_pkg::BUS_READ_WAIT && addr_q == tcc_pkg::OFF_CNT_L) begin
			tmp_q <= count_q[15:8];
		end else if (bus_q == tcc_pkg::BUS_READ_WAIT && addr_q == tcc_pkg::OFF_CAP_L) begin
			tmp_q <= capture_reg_q[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter, match blocking and retrigger

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= 16'h0000;
		end else if (wr && addr_q == tcc_pkg::OFF_CNT_L) begin
			count_q <= {tmp_q, wlo};
		end else if (tick) begin
			count_q <= top_hit ? 16'h0000 : count_q + 16'h0001;
		end
	end

	// Held from a counter write until the next timer tick, even when stopped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			block_q <= 1'b0;
		end else if (wr && addr_q == tcc_pkg::OFF_CNT_L) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rtg_pend_q <= 1'b0;
		end else if (capt_fire && ctrl_q.retrig_en) begin
			rtg_pend_q <= 1'b1;
		end else if (tick || !ctrl_q.retrig_en) begin
			rtg_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			top_q <= 1'b0;
		end else begin
			top_q <= (tick && top_hit && !rtg_pend_q) || (capt_fire && ctrl_q.retrig_en);
		end
	end

	assign top_reached = top_q;

	////////////////////////////////////////////////////////////////////////
	// Input capture

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capture_reg_q <= 16'h0000;
		end else if (capt_fire) begin
			capture_reg_q <= count_q;
		end else if (wr && addr_q == tcc_pkg::OFF_CAP_L && icr_is_top(ctrl_q.waveform_mode)) begin
			capture_reg_q <= {tmp_q, wlo};
		end
	end

	// Set wins over software and service clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capture_flag_q <= 1'b0;
		end else if (capt_fire) begin
			capture_flag_q <= 1'b1;
		end else if ((wr && addr_q == tcc_pkg::OFF_FLAG && hwdata[2]) || capt_irq_ack) begin
			capture_flag_q <= 1'b0;
		end
	end

	assign capt_irq_req = capture_flag_q && capt_irq_enable_q;

	////////////////////////////////////////////////////////////////////////
	// Compare registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 2; i++) begin
				cmp_act_q[i] <= tcc_pkg::CMP_RESET;
				cmp_buf_q[i] <= tcc_pkg::CMP_RESET;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pwm && tick && top_hit) begin
					cmp_act_q[i] <= cmp_buf_q[i];
				end
				if (wr && addr_q == (i == 0 ? tcc_pkg::OFF_CMPA_L : tcc_pkg::OFF_CMPB_L)) begin
					if (pwm) begin
						cmp_buf_q[i] <= {tmp_q, wlo};
					end else begin
						cmp_act_q[i] <= {tmp_q, wlo};
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare flags and requests

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_flag_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match[i]) begin
					compare_flag_q[i] <= 1'b1;
				end else if ((wr && addr_q == tcc_pkg::OFF_FLAG && hwdata[i]) || irq_ack[i]) begin
					compare_flag_q[i] <= 1'b0;
				end
			end
		end
	end

	assign irq_req = compare_flag_q & compare_irq_enable_q;

	////////////////////////////////////////////////////////////////////////
	// Output latches and pin override

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match[i] || force_cmp[i]) begin
					latch_q[i] <= on_match(i == 0 ? ctrl_q.com_a : ctrl_q.com_b, latch_q[i]);
				end else if (pwm && tick && top_hit) begin
					latch_q[i] <= at_count_lower_limit(i == 0 ? ctrl_q.com_a : ctrl_q.com_b, latch_q[i]);
				end
			end
		end
	end

	always_comb begin
		pin_out[0] = (ctrl_q.com_a != 2'h0) ? latch_q[0] : port_value[0];
		pin_out[1] = (ctrl_q.com_b != 2'h0) ? latch_q[1] : port_value[1];
		pin_oe     = pin_direction;
	end

endmodule // tcc_timer16
`default_nettype wire

// ---- tcc_timer16_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_monitor (
	input  wire logic        hclk,          // System clock
	input  wire logic        hresetn,       // Reset, active low
	input  wire logic        hsel,          // Slave select
	input  wire logic [1:0]  htrans,        // Transfer type
	input  wire logic        hwrite,        // Write when high
	input  wire logic        hready,        // Bus ready
	input  wire logic        hreadyout,     // Slave ready
	input  wire logic [31:0] hrdata,        // Read data
	input  wire logic        hresp,         // Response
	input  wire logic [1:0]  port_value,    // Port level
	input  wire logic [1:0]  pin_direction, // Direction bits
	input  wire logic [1:0]  pin_out,       // Pin level
	input  wire logic [1:0]  pin_oe,        // Pin enable
	input  wire logic [1:0]  irq_ack,       // Serviced pulses
	input  wire logic [1:0]  irq_req,       // Compare requests
	input  wire logic        capt_irq_req,  // Capture request
	input  wire logic        top_reached    // Top pulse
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("slave response not OKAY");
	read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read answer not after one wait cycle");
	write_ready_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write inserted a wait cycle");
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data changed outside a read");
	oe_follow_a: assert property (pin_oe == pin_direction)
		else $error("pin enable differs from direction bits");
	reset_pin_a: assert property (!$past(hresetn) |-> pin_out == port_value)
		else $error("pin not on port value after reset");
	reset_out_a: assert property (!$past(hresetn) |-> !top_reached && irq_req == 2'b00 && !capt_irq_req)
		else $error("request active right after reset");
	cmp_ack_a: assert property (irq_ack[0] && irq_req[0] |=> !irq_req[0])
		else $error("serviced compare request still active");
	top_pulse_a: assert property (top_reached |=> !top_reached)
		else $error("top pulse longer than one cycle");
endmodule // tcc_timer16_monitor
bind tcc_timer16 tcc_timer16_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.port_value(port_value), .pin_direction(pin_direction), .pin_out(pin_out), .pin_oe(pin_oe),
	.irq_ack(irq_ack), .irq_req(irq_req), .capt_irq_req(capt_irq_req), .top_reached(top_reached));
`default_nettype wire

// ---- tcc_isr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_isr_model (
	input  wire logic       hclk,       // System clock
	input  wire logic       hresetn,    // Reset, active low
	input  wire logic [1:0] irq_req,    // Compare requests
	input  wire logic       service_en, // Handler enabled
	input  wire logic       slow,       // Long response time
	output logic      [1:0] irq_ack     // Serviced pulses
);
	logic [3:0] wait_q;
	// Services channel A only, after the chosen response time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_q  <= 4'h0;
			irq_ack <= 2'b00;
		end else begin
			irq_ack <= 2'b00;
			if (!service_en || irq_req[0] !== 1'b1 || irq_ack[0]) begin
				wait_q <= 4'h0;
			end else if (wait_q == (slow ? 4'h5 : 4'h0)) begin
				irq_ack[0] <= 1'b1;
				wait_q     <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule // tcc_isr_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define check_eq(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	wire logic   hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        capture_event = 1'b0;
	logic [1:0]  irq_ack;
	logic [1:0]  port_value = 2'b10;
	logic [1:0]  pin_direction = 2'b00;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  irq_req;
	logic        capt_irq_req;
	logic        top_reached;
	logic        service_en = 1'b0;
	logic        slow = 1'b0;
	int          miscompares = 0;
	int          tests_run = 0;
	always #50 hclk = ~hclk;
	assign hready = hreadyout;
	tcc_timer16 i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .capture_event(capture_event), .irq_ack(irq_ack),
		.capt_irq_ack(1'b0), .port_value(port_value), .pin_direction(pin_direction), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq_req(irq_req), .capt_irq_req(capt_irq_req), .top_reached(top_reached));
	tcc_isr_model i_isr (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .service_en(service_en),
		.slow(slow), .irq_ack(irq_ack));
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic wr16(input logic [7:0] hi_a, input logic [15:0] v);
		wr(hi_a, {24'h000000, v[15:8]});
		wr(hi_a - 8'h04, {24'h000000, v[7:0]});
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		`check_eq(q & m, e)
	endtask
	task automatic pulse_cap;
		@(posedge hclk);
		capture_event <= 1'b1;
		@(posedge hclk);
		capture_event <= 1'b0;
	endtask
	task automatic watch(input int n, input bit top, output logic s);
		s = 1'b0;
		repeat (n) begin
			@(posedge hclk);
			if ((top ? top_reached : irq_ack[0]) === 1'b1) s = 1'b1;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic test_reset;
		chk(tcc_pkg::OFF_CTRL, 32'h3FF, {22'h0, tcc_pkg::CTRL_RESET});
		chk(tcc_pkg::OFF_STATUS, 32'h7, 32'h0);
		chk(8'h3C, 32'hFFFFFFFF, 32'h0);
		`check_eq(pin_out, port_value)
	endtask
	task automatic test_cmp_read;
		wr16(tcc_pkg::OFF_CMPB_H, 16'h1234);
		chk(tcc_pkg::OFF_CMPB_L, 32'hFF, 32'h34);
		chk(tcc_pkg::OFF_CMPB_H, 32'hFF, 32'h12);
		wr(tcc_pkg::OFF_CNT_H, 32'h56);
		chk(tcc_pkg::OFF_CMPB_H, 32'hFF, 32'h12);
		wr(tcc_pkg::OFF_CTRL, 32'h050);
		wr16(tcc_pkg::OFF_CMPB_H, 16'h0077);
		chk(tcc_pkg::OFF_CMPB_L, 32'hFF, 32'h77);
		wr(tcc_pkg::OFF_CTRL, 32'h000);
		chk(tcc_pkg::OFF_CMPB_L, 32'hFF, 32'h34);
		wr16(tcc_pkg::OFF_CNT_H, 16'h0000);
		wr(tcc_pkg::OFF_CTRL, 32'h250);
		repeat (300) @(posedge hclk);
		wr(tcc_pkg::OFF_CTRL, 32'h000);
		chk(tcc_pkg::OFF_CMPB_L, 32'hFF, 32'h77);
	endtask
	task automatic test_compare;
		logic [31:0] q;
		logic        s;
		wr(tcc_pkg::OFF_CTRL, 32'h040);
		wr(tcc_pkg::OFF_PRESC, 32'h0);
		wr16(tcc_pkg::OFF_CMPA_H, 16'h0010);
		wr16(tcc_pkg::OFF_CNT_H, 16'h0000);
		wr(tcc_pkg::OFF_FLAG, 32'h7);
		wr(tcc_pkg::OFF_CTRL, 32'h240);
		repeat (60) @(posedge hclk);
		wr(tcc_pkg::OFF_CTRL, 32'h040);
		chk(tcc_pkg::OFF_FLAG, 32'h1, 32'h1);
		xfer(1'b0, tcc_pkg::OFF_CNT_L, 32'h0, q);
		`check_eq(q[7:0] <= 8'h10, 1'b1)
		wr(tcc_pkg::OFF_FLAG, 32'h0);
		chk(tcc_pkg::OFF_FLAG, 32'h1, 32'h1);
		wr(tcc_pkg::OFF_FLAG, 32'h1);
		chk(tcc_pkg::OFF_FLAG, 32'h1, 32'h0);
		wr(tcc_pkg::OFF_IRQEN, 32'h1);
		slow       <= 1'b1;
		service_en <= 1'b1;
		wr(tcc_pkg::OFF_CTRL, 32'h240);
		watch(100, 1'b0, s);
		`check_eq(s, 1'b1)
		wr(tcc_pkg::OFF_CTRL, 32'h040);
		repeat (10) @(posedge hclk);
		`check_eq(irq_req[0], 1'b0)
		service_en <= 1'b0;
		wr(tcc_pkg::OFF_IRQEN, 32'h0);
		wr(tcc_pkg::OFF_FLAG, 32'h7);
	endtask
	task automatic test_force;
		pin_direction <= 2'b11;
		port_value    <= 2'b01;
		wr(tcc_pkg::OFF_CTRL, 32'h001);
		@(posedge hclk);
		`check_eq(pin_out[0], 1'b0)
		wr(tcc_pkg::OFF_FORCE, 32'h1);
		chk(tcc_pkg::OFF_STATUS, 32'h1, 32'h1);
		chk(tcc_pkg::OFF_FLAG, 32'h1, 32'h0);
		`check_eq(pin_out[0], 1'b1)
		wr(tcc_pkg::OFF_CTRL, 32'h051);
		wr(tcc_pkg::OFF_FORCE, 32'h1);
		chk(tcc_pkg::OFF_STATUS, 32'h1, 32'h1);
		port_value <= 2'b00;
		wr(tcc_pkg::OFF_CTRL, 32'h000);
		wr(tcc_pkg::OFF_FORCE, 32'h1);
		chk(tcc_pkg::OFF_STATUS, 32'h1, 32'h1);
		`check_eq(pin_out[0], 1'b0)
	endtask
	task automatic test_block;
		logic [31:0] q;
		wr(tcc_pkg::OFF_PRESC, 32'h3);
		wr16(tcc_pkg::OFF_CMPA_H, 16'h0005);
		wr16(tcc_pkg::OFF_CNT_H, 16'h0005);
		wr(tcc_pkg::OFF_FLAG, 32'h7);
		chk(tcc_pkg::OFF_STATUS, 32'h4, 32'h4);
		wr(tcc_pkg::OFF_CTRL, 32'h2F0);
		repeat (40) @(posedge hclk);
		wr(tcc_pkg::OFF_CTRL, 32'h000);
		chk(tcc_pkg::OFF_FLAG, 32'h1, 32'h0);
		chk(tcc_pkg::OFF_STATUS, 32'h4, 32'h0);
		xfer(1'b0, tcc_pkg::OFF_CNT_L, 32'h0, q);
		`check_eq(q[7:0] > 8'h05, 1'b1)
	endtask
	task automatic test_capture;
		wr(tcc_pkg::OFF_CTRL, 32'h003);
		wr16(tcc_pkg::OFF_CNT_H, 16'h1234);
		pulse_cap();
		chk(tcc_pkg::OFF_FLAG, 32'h4, 32'h4);
		chk(tcc_pkg::OFF_CAP_L, 32'hFF, 32'h34);
		chk(tcc_pkg::OFF_CAP_H, 32'hFF, 32'h12);
		wr16(tcc_pkg::OFF_CNT_H, 16'h4321);
		pulse_cap();
		wr(tcc_pkg::OFF_IRQEN, 32'h4);
		chk(tcc_pkg::OFF_CAP_L, 32'hFF, 32'h21);
		chk(tcc_pkg::OFF_CAP_H, 32'hFF, 32'h43);
		`check_eq(capt_irq_req, 1'b1)
		wr(tcc_pkg::OFF_FLAG, 32'h4);
		chk(tcc_pkg::OFF_FLAG, 32'h4, 32'h0);
		`check_eq(capt_irq_req, 1'b0)
		wr(tcc_pkg::OFF_IRQEN, 32'h0);
	endtask
	task automatic test_retrig;
		logic s;
		wr(tcc_pkg::OFF_PRESC, 32'h0);
		wr16(tcc_pkg::OFF_CNT_H, 16'h0000);
		wr(tcc_pkg::OFF_CTRL, 32'h200);
		pulse_cap();
		watch(20, 1'b1, s);
		`check_eq(s, 1'b0)
		wr(tcc_pkg::OFF_CTRL, 32'h300);
		pulse_cap();
		watch(20, 1'b1, s);
		`check_eq(s, 1'b1)
		wr(tcc_pkg::OFF_CTRL, 32'h000);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_cmp_read();
		test_compare();
		test_force();
		test_block();
		test_capture();
		test_retrig();
		print_verdict();
	end
	initial begin
		#(30000 * 100);
		miscompares++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire
